// *** hw/sew_ctrl.sv ***
// Command-side control of a small SPI EEPROM: write enable, protection,
// page loading, hold and power-on write lockout.
// Assumes the cell array is programmed elsewhere from prog_* outputs.
//
// Functional notes
// - Protect bits select none, quarter, half, all
// - Locked status plus low pin discards status writes
// - High protect pin allows status writes despite lock
// - Status bits 4-6 fixed, never written
// - Command 06h sets write-enable latch
// - Command 04h clears write-enable latch
// - Array write: 02h, address, data, select rise
// - Only low six address bits increment
// - Over 64 bytes keeps last 64
// - Select rise off byte boundary aborts write
// - Page program finishes within 5 ms
// - Hold enters on fall with clock low
// - Select rise ends hold, resets command machine
// - Hold floats output, ignores input and clock
// - Partial-byte array data rejected
// - Overlong status write rejected
// - Power-on lockout blocks all writes
// - Latch clears at power-on and write completion
// - Rejected writes leave latch unchanged
// - Latch low ignores write commands
// - Busy bit high during internal write
`timescale 1ns/1ps
module sew_ctrl
    import sew_pkg::*;
#(
    parameter int PROG_CYCLES = PROG_CYC,
    parameter int POR_CYCLES = PU_WRITE_CYC
) (
    input wire logic clock, // System clock
    input wire logic sys_rst, // Power-on reset, high
    input wire logic link_sck, // Serial clock from host
    input wire logic cs_n, // Chip select, low active
    input wire logic si, // Serial data in
    input wire logic hold_n, // Hold, low active
    input wire logic wp_n, // Write-protect pin, low active
    input wire logic [PAGE_AW-1:0] rd_idx, // Page buffer read index
    output logic [7:0] rd_data_ff, // Page buffer read data
    output sew_status_t status_ff, // Status byte
    output logic prog_start_ff, // Program start pulse
    output logic [7:0] prog_page_ff, // Page address A13..A6
    output logic [PAGE_BYTES-1:0] prog_mask_ff, // Loaded byte mask
    output logic cmd_reject_ff, // Frame refused pulse
    output logic hold_state_ff, // In hold state
    output logic so_o_ff, // Serial out data
    output logic so_oe_ff, // Serial out enable
    output logic por_done_ff // Writes allowed
);

    if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << TMR_W) ||
        POR_CYCLES < 1 || POR_CYCLES >= (1 << TMR_W)) begin : g_bad_param
        $error("sew_ctrl: cycle counts out of range");
    end

    // ************************************************************
    // Link domain: bit counter, reset by select
    // ************************************************************
    logic [2:0] bcnt_ff, nxt_bcnt;
    logic [2:0] bgray_ff, nxt_bgray;

    // Hold gates the clock; host only moves hold while clock is low
    always_comb begin
        nxt_bcnt = hold_n ? bcnt_ff + 3'h1 : bcnt_ff;
        nxt_bgray = nxt_bcnt ^ (nxt_bcnt >> 1);
    end

    // Select high clears the count so each frame starts aligned
    always_ff @(posedge link_sck or posedge cs_n) begin
        if (cs_n) begin
            bcnt_ff <= 3'h0;
            bgray_ff <= 3'h0;
        end else begin
            bcnt_ff <= nxt_bcnt;
            bgray_ff <= nxt_bgray;
        end
    end

    // ************************************************************
    // Link domain: shifter, byte word and byte toggle
    // ************************************************************
    logic [6:0] shift_ff, nxt_shift;
    logic [7:0] lbyte_ff, nxt_lbyte;
    logic btgl_ff, nxt_btgl;

    always_comb begin
        nxt_shift = shift_ff;
        nxt_lbyte = lbyte_ff;
        nxt_btgl = btgl_ff;
        if (hold_n) begin
            nxt_shift = {shift_ff[5:0], si};
            if (bcnt_ff == 3'h7) begin
                nxt_lbyte = {shift_ff, si};
                nxt_btgl = ~btgl_ff;
            end
        end
    end

    // Toggle is not reset by select, else a frame end fakes a byte
    always_ff @(posedge link_sck or posedge sys_rst) begin
        if (sys_rst) begin
            shift_ff <= 7'h00;
            lbyte_ff <= 8'h00;
            btgl_ff <= 1'b0;
        end else begin
            shift_ff <= nxt_shift;
            lbyte_ff <= nxt_lbyte;
            btgl_ff <= nxt_btgl;
        end
    end

    // ************************************************************
    // System domain: synchronisers
    // ************************************************************
    logic [1:0] cs_s_ff, sck_s_ff, hold_s_ff, wp_s_ff, tgl_s_ff;
    logic [2:0] g_s1_ff, g_s2_ff, g_d1_ff, g_d2_ff;
    logic cs_d_ff, hold_d_ff, tgl_d_ff;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cs_s_ff <= 2'h3;
            sck_s_ff <= 2'h0;
            hold_s_ff <= 2'h3;
            wp_s_ff <= 2'h0;
            tgl_s_ff <= 2'h0;
            g_s1_ff <= 3'h0;
            g_s2_ff <= 3'h0;
            g_d1_ff <= 3'h0;
            g_d2_ff <= 3'h0;
            cs_d_ff <= 1'b1;
            hold_d_ff <= 1'b1;
            tgl_d_ff <= 1'b0;
        end else begin
            cs_s_ff <= {cs_s_ff[0], cs_n};
            sck_s_ff <= {sck_s_ff[0], link_sck};
            hold_s_ff <= {hold_s_ff[0], hold_n};
            wp_s_ff <= {wp_s_ff[0], wp_n};
            tgl_s_ff <= {tgl_s_ff[0], btgl_ff};
            g_s1_ff <= bgray_ff;
            g_s2_ff <= g_s1_ff;
            g_d1_ff <= g_s2_ff;
            g_d2_ff <= g_d1_ff;
            cs_d_ff <= cs_s_ff[1];
            hold_d_ff <= hold_s_ff[1];
            tgl_d_ff <= tgl_s_ff[1];
        end
    end

    // Count reset and select rise arrive together; the delayed copy
    // still shows the count from before the rise
    logic cs_rise, cs_fall, byte_ev, aligned, wp_hi;
    logic [7:0] rx_byte;
    assign cs_rise = cs_s_ff[1] & ~cs_d_ff;
    assign cs_fall = ~cs_s_ff[1] & cs_d_ff;
    assign byte_ev = tgl_s_ff[1] ^ tgl_d_ff;
    assign aligned = (g_d2_ff == 3'h0);
    assign wp_hi = wp_s_ff[1];
    assign rx_byte = lbyte_ff; // Stable for a full byte time after toggle

    // ************************************************************
    // Hold state
    // ************************************************************
    logic nxt_hold;

    always_comb begin
        nxt_hold = hold_state_ff;
        if (cs_s_ff[1]) begin
            nxt_hold = 1'b0;
        end else if (hold_d_ff & ~hold_s_ff[1] & ~sck_s_ff[1]) begin
            nxt_hold = 1'b1;
        end else if (~hold_d_ff & hold_s_ff[1]) begin
            nxt_hold = 1'b0;
        end
    end

    // ************************************************************
    // Command machine, latch, protection, program timer
    // ************************************************************
    sew_state_t st_ff, nxt_st;
    logic [13:0] addr_ff, nxt_addr;
    logic [PAGE_BYTES-1:0] mask_ff, nxt_mask;
    logic [7:0] sr_ff, nxt_sr;
    logic [1:0] bp_ff, nxt_bp;
    logic lock_ff, nxt_lock, wel_ff, nxt_wel, busy_ff, nxt_busy;
    logic one_set_ff, nxt_one_set, nxt_start, nxt_rej, buf_we;
    logic [TMR_W-1:0] tmr_ff, nxt_tmr, por_ff, nxt_por;
    logic [7:0] page_buf [PAGE_BYTES];
    logic wr_ok;

    // Writes need latch set, no program running, power-up complete
    assign wr_ok = wel_ff & ~busy_ff & por_done_ff;

    always_comb begin
        nxt_st = st_ff;
        nxt_addr = addr_ff;
        nxt_mask = mask_ff;
        nxt_sr = sr_ff;
        nxt_bp = bp_ff;
        nxt_lock = lock_ff;
        nxt_wel = wel_ff;
        nxt_busy = busy_ff;
        nxt_tmr = tmr_ff;
        nxt_one_set = one_set_ff;
        nxt_start = 1'b0;
        nxt_rej = 1'b0;
        buf_we = 1'b0;
        nxt_por = (por_ff == '0) ? por_ff : por_ff - 1'b1;
        // Internal write cycle; latch drops when it ends
        if (busy_ff) begin
            if (tmr_ff == TMR_W'(1)) begin
                nxt_busy = 1'b0;
                nxt_wel = 1'b0;
            end else begin
                nxt_tmr = tmr_ff - 1'b1;
            end
        end
        if (cs_rise) begin
            nxt_st = ST_IDLE;
            case (st_ff)
                ST_ONE: begin
                    if (aligned) begin
                        nxt_wel = one_set_ff;
                    end else begin
                        nxt_rej = 1'b1;
                    end
                end
                ST_SRD: begin
                    // Status data sits in sr_ff once its byte completed
                    if (aligned && one_set_ff) begin
                        nxt_bp = sr_ff[STS_BP_LSB +: 2];
                        nxt_lock = sr_ff[STS_LOCK_BIT];
                        nxt_busy = 1'b1;
                        nxt_tmr = TMR_W'(PROG_CYCLES);
                    end else begin
                        nxt_rej = 1'b1;
                    end
                end
                ST_DATA: begin
                    if (aligned && (mask_ff != '0)) begin
                        nxt_start = 1'b1;
                        nxt_busy = 1'b1;
                        nxt_tmr = TMR_W'(PROG_CYCLES);
                    end else begin
                        nxt_rej = 1'b1;
                    end
                end
                ST_IDLE, ST_CMD: nxt_rej = 1'b0;
                default: nxt_rej = 1'b1;
            endcase
        end else if (cs_fall) begin
            nxt_st = ST_CMD;
            nxt_one_set = 1'b0;
        end else if (byte_ev && !nxt_hold) begin
            case (st_ff)
                ST_CMD: begin
                    case (rx_byte)
                        CMD_SET_WE: begin
                            nxt_one_set = 1'b1;
                            nxt_st = (busy_ff || !por_done_ff) ? ST_SKIP : ST_ONE;
                        end
                        CMD_CLR_WE: begin
                            nxt_one_set = 1'b0;
                            nxt_st = busy_ff ? ST_SKIP : ST_ONE;
                        end
                        CMD_ARRAY_WR: nxt_st = wr_ok ? ST_AHI : ST_SKIP;
                        CMD_STATUS_WR: begin
                            // Locked only while the pin is low
                            nxt_st = (wr_ok && (!lock_ff || wp_hi)) ?
                                ST_SRD : ST_SKIP;
                        end
                        default: nxt_st = ST_SKIP;
                    endcase
                end
                ST_AHI: begin
                    nxt_addr[13:8] = rx_byte[5:0]; // Top two bits ignored
                    nxt_st = ST_ALO;
                end
                ST_ALO: begin
                    nxt_addr[7:0] = rx_byte;
                    nxt_mask = '0;
                    nxt_st = sew_prot_hit(bp_ff, {addr_ff[13:8], rx_byte}) ?
                        ST_SKIP : ST_DATA;
                end
                ST_DATA: begin
                    buf_we = 1'b1;
                    nxt_mask[addr_ff[PAGE_AW-1:0]] = 1'b1;
                    nxt_addr[PAGE_AW-1:0] = addr_ff[PAGE_AW-1:0] + 1'b1;
                end
                ST_SRD: begin
                    // Second data byte marks an overlong status write
                    nxt_sr = rx_byte;
                    nxt_st = one_set_ff ? ST_SKIP : ST_SRD;
                    nxt_one_set = ~one_set_ff;
                    if (one_set_ff) begin
                        nxt_one_set = 1'b0;
                    end
                end
                ST_ONE: nxt_st = ST_SKIP;
                default: nxt_st = st_ff;
            endcase
        end
    end

    // Registers of the command side; nonvolatile bits reset to defaults
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_ff <= ST_IDLE;
            addr_ff <= 14'h0000;
            mask_ff <= '0;
            sr_ff <= 8'h00;
            bp_ff <= BP_RST;
            lock_ff <= LOCK_RST;
            wel_ff <= 1'b0;
            busy_ff <= 1'b0;
            tmr_ff <= '0;
            por_ff <= TMR_W'(POR_CYCLES);
            one_set_ff <= 1'b0;
            hold_state_ff <= 1'b0;
            prog_start_ff <= 1'b0;
            prog_page_ff <= 8'h00;
            prog_mask_ff <= '0;
            cmd_reject_ff <= 1'b0;
            status_ff <= '0;
            so_o_ff <= 1'b0;
            so_oe_ff <= 1'b0;
            por_done_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            addr_ff <= nxt_addr;
            mask_ff <= nxt_mask;
            sr_ff <= nxt_sr;
            bp_ff <= nxt_bp;
            lock_ff <= nxt_lock;
            wel_ff <= nxt_wel;
            busy_ff <= nxt_busy;
            tmr_ff <= nxt_tmr;
            por_ff <= nxt_por;
            one_set_ff <= nxt_one_set;
            hold_state_ff <= nxt_hold;
            prog_start_ff <= nxt_start;
            prog_page_ff <= nxt_addr[13:6];
            prog_mask_ff <= nxt_mask;
            cmd_reject_ff <= nxt_rej;
            status_ff <= '{lock_ff, STS_RSV_VAL, bp_ff[1], bp_ff[0], wel_ff,
                busy_ff};
            so_o_ff <= 1'b0; // Read path lives outside this block
            so_oe_ff <= 1'b0;
            por_done_ff <= (por_ff == '0);
        end
    end

    // ************************************************************
    // Page buffer: later bytes overwrite earlier ones in place
    // ************************************************************
    always_ff @(posedge clock) begin
        if (buf_we) begin
            page_buf[addr_ff[PAGE_AW-1:0]] <= rx_byte;
        end
        rd_data_ff <= page_buf[rd_idx];
    end

endmodule : sew_ctrl

// *** hw/sew_pkg.sv ***
// Shared constants and types for the SPI EEPROM write-protect controller.
// Assumes a 200 MHz system clock and a host-driven serial clock.
package sew_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 200;
    localparam int T_PROG_MS = 5;
    localparam int T_PU_WRITE_MS = 10;
    localparam int T_PU_READ_US = 10;
    localparam int PROG_CYC = T_PROG_MS * CLK_MHZ * 1000;
    localparam int PU_WRITE_CYC = T_PU_WRITE_MS * CLK_MHZ * 1000;
    localparam int PU_READ_CYC = T_PU_READ_US * CLK_MHZ;
    localparam int TMR_W = 22;

    // ************************************************************
    // Commands, protection, layout, reset values
    // ************************************************************
    localparam logic [7:0] CMD_SET_WE = 8'h06;
    localparam logic [7:0] CMD_CLR_WE = 8'h04;
    localparam logic [7:0] CMD_ARRAY_WR = 8'h02;
    localparam logic [7:0] CMD_STATUS_WR = 8'h01;
    localparam logic [13:0] PROT_QTR_BASE = 14'h3000;
    localparam logic [13:0] PROT_HALF_BASE = 14'h2000;
    localparam logic [13:0] PROT_ALL_BASE = 14'h0000;
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_AW = 6;
    localparam int STS_BP_LSB = 2;
    localparam int STS_LOCK_BIT = 7;
    localparam logic [2:0] STS_RSV_VAL = 3'h0;
    localparam logic [1:0] BP_RST = 2'h0;
    localparam logic LOCK_RST = 1'b0;

    typedef struct packed {
        logic status_lock;
        logic [2:0] rsv;
        logic prot_level_hi;
        logic prot_level_lo;
        logic wel;
        logic busy;
    } sew_status_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CMD = 3'b001,
        ST_ONE = 3'b010,
        ST_AHI = 3'b011,
        ST_ALO = 3'b100,
        ST_DATA = 3'b101,
        ST_SRD = 3'b110,
        ST_SKIP = 3'b111
    } sew_state_t;

    // Block-protect level against a 14-bit array address
    function automatic logic sew_prot_hit(input logic [1:0] bp, input logic [13:0] addr);
        case (bp)
            2'h1: sew_prot_hit = (addr >= PROT_QTR_BASE);
            2'h2: sew_prot_hit = (addr >= PROT_HALF_BASE);
            2'h3: sew_prot_hit = (addr >= PROT_ALL_BASE);
            default: sew_prot_hit = 1'b0;
        endcase
    endfunction : sew_prot_hit

endpackage : sew_pkg

// *** verification/sew_host_model.sv ***
// Host end of the serial link: select, clock, data and hold.
// Assumes the caller spaces frames; the link clock runs only in frames.
`timescale 1ns/1ps
module sew_host_model (
    output logic link_sck, // Serial clock
    output logic cs_n, // Select, low active
    output logic si, // Serial data
    output logic hold_n // Hold, low active
);
    // ************************************************************
    // Frame driver
    // ************************************************************
    localparam realtime HP = 62.5;
    // Select parked high from power-up
    initial begin
        link_sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b0;
        hold_n = 1'b1;
    end
    // Data moves with the clock low, taken on the rise
    task automatic bit_out(input logic b);
        si = b;
        #HP link_sck = 1'b1;
        #HP link_sck = 1'b0;
    endtask : bit_out
    // Hold moves only with the clock low; pulses inside are junk
    task automatic pause;
        hold_n = 1'b0;
        #HP;
        repeat (2) bit_out(~si);
        #HP hold_n = 1'b1;
    endtask : pause
    // Bytes MSB first, ex stray bits, hold before bit hd
    task automatic frame(input logic [7:0] q[$], input int ex, input int hd);
        int n;
        n = 0;
        #1.3 cs_n = 1'b0;
        #HP;
        foreach (q[i]) begin
            for (int j = 7; j >= 0; j--) begin
                if (n == hd) pause();
                bit_out(q[i][j]);
                n++;
            end
        end
        repeat (ex) bit_out(1'b1);
        si = ~si; // Line not held after the last bit
        #HP cs_n = 1'b1;
        si = ~si;
        #(8 * HP);
    endtask : frame
endmodule : sew_host_model

// *** verification/sew_ctrl_properties.sv ***
// Port checks for the write-protect controller.
// Assumes one system clock and an active-high async reset.
`timescale 1ns/1ps
module sew_ctrl_properties
    import sew_pkg::*;
#(
    parameter int PROG_CYCLES = 20,
    parameter int POR_CYCLES = 20
) (
    input wire logic clock, // Clock
    input wire logic sys_rst, // Reset
    input wire logic cs_n, // Select
    input wire logic wp_n, // Protect pin
    input wire sew_status_t status_ff, // Status
    input wire logic prog_start_ff, // Program pulse
    input wire logic [PAGE_BYTES-1:0] prog_mask_ff, // Byte mask
    input wire logic cmd_reject_ff, // Refusal pulse
    input wire logic hold_state_ff, // Hold level
    input wire logic so_oe_ff, // Output enable
    input wire logic por_done_ff // Writes allowed
);
    // ************************************************************
    // Helpers and properties
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    int busy_cnt_ff;
    int nxt_busy_cnt;
    // Busy length; a stuck busy shows as a long count
    always_comb nxt_busy_cnt = status_ff.busy ? busy_cnt_ff + 1 : 0;
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) busy_cnt_ff <= 0;
        else busy_cnt_ff <= nxt_busy_cnt;
    end
    sequence s_locked;
        (status_ff.status_lock && !wp_n) [*8];
    endsequence
    sequence s_idle;
        cs_n [*8];
    endsequence
    rsv_bits_fixed_a: assert property (status_ff.rsv == STS_RSV_VAL)
        else $error("reserved status bits moved");
    prog_sets_busy_a: assert property (prog_start_ff |-> ##[0:2] status_ff.busy)
        else $error("program start without busy");
    prog_pulse_a: assert property (prog_start_ff |-> prog_mask_ff != '0 ##1 !prog_start_ff)
        else $error("bad program pulse");
    por_lockout_a: assert property (!por_done_ff |-> !prog_start_ff && !$rose(status_ff.wel))
        else $error("write acted before power-on done");
    busy_length_a: assert property ($fell(status_ff.busy) |->
        busy_cnt_ff >= PROG_CYCLES - 2 && busy_cnt_ff <= PROG_CYCLES + 2)
        else $error("program cycle length wrong");
    wel_auto_clear_a: assert property ($fell(status_ff.busy) |-> ##[0:1] !status_ff.wel)
        else $error("latch not cleared after write");
    lock_keeps_a: assert property (s_locked |=> $stable(status_ff[7:2]))
        else $error("locked status changed");
    hold_ends_a: assert property (s_idle |-> !hold_state_ff)
        else $error("hold survives deselect");
    hold_float_a: assert property (hold_state_ff |-> !so_oe_ff)
        else $error("output driven in hold");
    reject_quiet_a: assert property (cmd_reject_ff |->
        !prog_start_ff ##1 (!cmd_reject_ff && $stable(status_ff[7:1])))
        else $error("refused frame had an effect");
endmodule : sew_ctrl_properties

bind sew_ctrl sew_ctrl_properties #(.PROG_CYCLES(PROG_CYCLES), .POR_CYCLES(POR_CYCLES))
    sew_ctrl_properties_i (.clock, .sys_rst, .cs_n, .wp_n, .status_ff, .prog_start_ff,
    .prog_mask_ff, .cmd_reject_ff, .hold_state_ff, .so_oe_ff, .por_done_ff);

// *** verification/tb.sv ***
// Self-checking bench for the write-protect controller.
// Assumes the host model drives the link; the bench drives the other pins.
`timescale 1ns/1ps
module tb;
    import sew_pkg::*;
    // ************************************************************
    // Signals, design and host
    // ************************************************************
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic wp_n = 1'b0;
    logic [PAGE_AW-1:0] rd_idx = '0;
    logic link_sck, cs_n, si, hold_n, prog_start_ff, cmd_reject_ff;
    logic hold_state_ff, so_o_ff, so_oe_ff, por_done_ff;
    logic [7:0] rd_data_ff, prog_page_ff, pg;
    logic [PAGE_BYTES-1:0] prog_mask_ff, mk;
    sew_status_t status_ff;
    int bad_count = 0;
    int total_checks = 0;
    int n_pg = 0;
    int n_rj = 0;
    always #2.5 clock = ~clock;
    sew_ctrl #(.PROG_CYCLES(20), .POR_CYCLES(400)) sew_ctrl_i (
        .clock, .sys_rst, .link_sck, .cs_n, .si, .hold_n, .wp_n, .rd_idx, .rd_data_ff,
        .status_ff, .prog_start_ff, .prog_page_ff, .prog_mask_ff, .cmd_reject_ff,
        .hold_state_ff, .so_o_ff, .so_oe_ff, .por_done_ff);
    sew_host_model sew_host_model_i (.link_sck, .cs_n, .si, .hold_n);
    // Pulses last one clock, so count them mid-cycle
    always @(negedge clock) begin
        if (prog_start_ff === 1'b1) begin
            n_pg++;
            pg = prog_page_ff;
            mk = prog_mask_ff;
        end
        if (cmd_reject_ff === 1'b1) n_rj++;
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // One frame, then refusal and program counts; waits out busy
    task automatic op(input logic [7:0] q[$], input int ex, input int hd, input logic rj,
                      input int pr);
        int r0;
        int p0;
        r0 = n_rj;
        p0 = n_pg;
        sew_host_model_i.frame(q, ex, hd);
        repeat (4) @(negedge clock);
        chk("refused", rj, n_rj - r0);
        chk("programmed", pr, n_pg - p0);
        for (int i = 0; i < 100 && status_ff.busy !== 1'b0; i++) @(negedge clock);
        if (status_ff.busy !== 1'b0) begin
            bad_count++;
            results();
        end
    endtask : op
    task automatic we;
        op({CMD_SET_WE}, 0, -1, 1'b0, 0);
    endtask : we
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        logic [15:0] a;
        logic hit;
        logic [7:0] q[$];
        repeat (4) @(negedge clock);
        sys_rst = 1'b0;
        @(negedge clock);
        chk("status", 8'h00, status_ff);
        op({CMD_SET_WE}, 0, -1, 1'b1, 0);
        chk("wel", 1'b0, status_ff.wel);
        for (int i = 0; i < 1000 && por_done_ff !== 1'b1; i++) @(negedge clock);
        chk("por", 1'b1, por_done_ff);
        if (por_done_ff !== 1'b1) results();
        op({8'h03, CMD_SET_WE}, 0, -1, 1'b1, 0);
        chk("wel", 1'b0, status_ff.wel);
        op({CMD_ARRAY_WR, 8'h00, 8'h00, 8'h55}, 0, -1, 1'b1, 0);
        we();
        chk("wel", 1'b1, status_ff.wel);
        op({CMD_CLR_WE}, 0, -1, 1'b0, 0);
        chk("wel", 1'b0, status_ff.wel);
        we();
        op({CMD_STATUS_WR, 8'hF4}, 0, -1, 1'b0, 0);
        chk("status", 8'h84, status_ff);
        we();
        op({CMD_STATUS_WR, 8'h00}, 0, -1, 1'b1, 0);
        chk("status", 8'h86, status_ff);
        wp_n = 1'b1;
        op({CMD_STATUS_WR, 8'h00, 8'h00}, 0, -1, 1'b1, 0);
        chk("status", 8'h86, status_ff);
        op({CMD_STATUS_WR, 8'h00}, 0, -1, 1'b0, 0);
        chk("status", 8'h00, status_ff);
        // Each level against the last page below each region boundary
        for (int bp = 0; bp < 4; bp++) begin
            we();
            op({CMD_STATUS_WR, 8'(bp * 4)}, 0, -1, 1'b0, 0);
            for (int k = 1; k < 4; k++) begin
                a = 16'h0FC0 + 16'(k * 4096);
                hit = (bp == 3) || (bp == 2 && k > 1) || (bp == 1 && k == 3);
                we();
                op({CMD_ARRAY_WR, a[15:8], a[7:0], 8'hA5}, 0, -1, hit, int'(!hit));
                chk("wel", hit, status_ff.wel);
                if (!hit) chk("page", a[13:6], pg);
                if (!hit) chk("mask", 64'h1, mk);
            end
        end
        we();
        op({CMD_STATUS_WR, 8'h00}, 0, -1, 1'b0, 0);
        // Start near page end, overrun by two bytes
        q = {CMD_ARRAY_WR, 8'hDF, 8'h7E};
        for (int k = 1; k <= 66; k++) q.push_back(8'(k));
        we();
        op(q, 0, -1, 1'b0, 1);
        chk("page", 8'h7D, pg);
        chk("mask", '1, mk);
        rd_idx = 6'h3E;
        repeat (2) @(negedge clock);
        chk("byte", 8'h41, rd_data_ff);
        rd_idx = 6'h00;
        repeat (2) @(negedge clock);
        chk("byte", 8'h03, rd_data_ff);
        we();
        op({CMD_ARRAY_WR, 8'h00, 8'h00, 8'h11}, 3, -1, 1'b1, 0);
        chk("wel", 1'b1, status_ff.wel);
        fork
            op({CMD_CLR_WE}, 0, 4, 1'b0, 0);
            begin
                for (int i = 0; i < 400 && hold_n !== 1'b0; i++) @(negedge clock);
                repeat (8) @(negedge clock);
                chk("hold", 1'b1, hold_state_ff);
                chk("so_oe", 1'b0, so_oe_ff);
                chk("so", 1'b0, so_o_ff);
            end
        join
        chk("hold", 1'b0, hold_state_ff);
        chk("wel", 1'b0, status_ff.wel);
        results();
    end
endmodule : tb
